// >>> dfr_pkg.sv
// constants for the keyed frequency select and ramp logic
// assumes a single 50 MHz system clock and byte-wide register writes
package dfr_pkg;

  localparam int unsigned DFR_FW = 48;
  localparam int unsigned DFR_RW = 20;
  localparam int unsigned DFR_AW = 6;
  localparam int unsigned DFR_NREG = 32;

  // byte offsets, most significant byte at the lowest offset
  localparam logic [5:0] DFR_ADDR_F1  = 6'h04;
  localparam logic [5:0] DFR_ADDR_F2  = 6'h0a;
  localparam logic [5:0] DFR_ADDR_DFW = 6'h10;
  localparam logic [5:0] DFR_ADDR_RRC = 6'h1a;
  localparam logic [5:0] DFR_ADDR_CTL = 6'h1f;
  localparam int unsigned DFR_WORD_BYTES = 6;

  // control byte fields
  localparam int unsigned DFR_CTL_CLR1_BIT = 7;
  localparam int unsigned DFR_CTL_CLR2_BIT = 6;
  localparam int unsigned DFR_CTL_TRI_BIT  = 5;
  localparam int unsigned DFR_CTL_MODE_LSB = 1;

  // reset values
  localparam logic [7:0]        DFR_BYTE_RST = 8'h00;
  localparam logic [DFR_FW-1:0] DFR_WORD_RST = 48'h0;
  localparam logic [DFR_RW-1:0] DFR_RRC_RST  = 20'h00000;
  localparam logic [2:0]        DFR_SYNC_RST = 3'h0;

  typedef enum logic [2:0] {
    DFR_MODE_SINGLE = 3'h0,
    DFR_MODE_FSK    = 3'h1,
    DFR_MODE_RAMP   = 3'h2,
    DFR_MODE_CHIRP  = 3'h3,
    DFR_MODE_BPSK   = 3'h4
  } dfr_mode_t;

endpackage : dfr_pkg

// >>> dfr_ramp_if.sv
// link between the ramp control and the ramp-rate down counter
// assumes both ends share clk_i
interface dfr_ramp_if;
  import dfr_pkg::*;
  logic              run;
  logic              restart;
  logic [DFR_RW-1:0] period;
  logic              tick;
  modport ctl (output run, output restart, output period, input  tick);
  modport cnt (input  run, input  restart, input  period, output tick);
endinterface : dfr_ramp_if

// >>> dfr_ramp_cnt.sv
// ramp-rate down counter: one tick every period+1 clocks while running
// assumes period is held stable by the update logic between reloads
module dfr_ramp_cnt
  import dfr_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // control link
  dfr_ramp_if.cnt   rif
);

  logic [DFR_RW-1:0] cnt_q;

  // reload on stop, restart and zero; new period taken at each reload
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= DFR_RRC_RST;
    end else if (!rif.run || rif.restart || cnt_q == '0) begin
      cnt_q <= rif.period;
    end else begin
      cnt_q <= cnt_q - 20'h00001;
    end
  end

  assign rif.tick = rif.run && !rif.restart && (cnt_q == '0);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_CNT_DOWN: assert property (
    (rif.run && !rif.restart && cnt_q != '0) |=>
      (!rif.run || rif.restart || cnt_q == $past(cnt_q) - 20'h00001))
    else $error("ramp counter did not count down");
  AST_CNT_RELOAD: assert property (
    rif.tick |=> (cnt_q == $past(rif.period)))
    else $error("ramp counter not reloaded after tick");

endmodule : dfr_ramp_cnt

// >>> dfr_freq_ctl.sv
// keyed frequency select and ramped sweep ahead of the phase accumulator
// assumes writes and update pulses come from logic on clk_i; keying pin is asynchronous
//
// Functional notes
// - unramped keying picks word by pin level
// - word switch keeps phase, no accumulator reset
// - otherwise unramped keying equals single tone
// - mode 010 ramps between the words
// - ramp counter counts down, pulses at zero
// - pin level change starts the ramp counter
// - one pulse every N+1 clocks
// - pulses step accumulator, stop at destination
// - hold end frequency while pin unchanged
// - each pulse adds or subtracts step word
// - offset combined with tuning word feeds phase
// - early pin toggle reverses ramp at once
// - triangle bit sweeps automatically, ignores pin
// - triangle sweep linear with equal dwell
// - triangle start word follows pin if mode 010 already set at enable, else first word
// - step and period changes apply on fly
// - accumulator clear is one-clock one-shot restart
// - clear bit held retriggers on every update
// - full clear holds both accumulators at zero
module dfr_freq_ctl
  import dfr_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  // register write port
  input  wire logic                  wr_en_i,
  input  wire logic [DFR_AW-1:0]     wr_addr_i,
  input  wire logic [7:0]            wr_data_i,
  input  wire logic                  update_i,
  // register read port
  input  wire logic [DFR_AW-1:0]     rd_addr_i,
  output logic      [7:0]            rd_data_o,
  // keying pin
  input  wire logic                  keying_select_pin_i,
  // datapath outputs
  output logic      [DFR_FW-1:0]     tuning_word_o,
  output logic      [DFR_FW-1:0]     phase_o,
  output logic                       ramp_busy_o
);
  import dfr_pkg::*;

  logic [7:0]        shd_q [DFR_NREG];
  logic [DFR_FW-1:0] f1_sh, f2_sh, dfw_sh;
  logic [DFR_RW-1:0] rrc_sh;
  logic [DFR_FW-1:0] f1_q, f2_q, dfw_q;
  logic [DFR_RW-1:0] rrc_q;
  logic [7:0]        ctl_q;
  logic [2:0]        key_s_q;
  logic              key_q;
  logic              key_chg;
  logic              clr1_q;
  logic              tri_rise;
  logic              dir_up_q;
  logic [DFR_FW-1:0] acc_q;
  logic [DFR_FW-1:0] span;
  logic              at_dest;
  logic              step_up;
  logic [DFR_FW-1:0] ftw_q;
  logic [DFR_FW-1:0] phase_q;
  logic [7:0]        rd_data_q;
  logic              busy_q;
  dfr_mode_t         mode;
  logic              clr2;
  logic              tri_on;
  logic              ramp_mode;

  dfr_ramp_if rif ();

  dfr_ramp_cnt u_cnt (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .rif     (rif.cnt)
  );

  // register shadow bytes, written any time
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DFR_NREG; i++) begin
        shd_q[i] <= DFR_BYTE_RST;
      end
    end else if (wr_en_i && wr_addr_i < 6'(DFR_NREG)) begin
      shd_q[wr_addr_i[4:0]] <= wr_data_i;
    end
  end

  // gather shadow bytes into words
  always_comb begin
    f1_sh  = DFR_WORD_RST;
    f2_sh  = DFR_WORD_RST;
    dfw_sh = DFR_WORD_RST;
    for (int k = 0; k < DFR_WORD_BYTES; k++) begin
      f1_sh[DFR_FW-1-8*k -: 8]  = shd_q[int'(DFR_ADDR_F1) + k];
      f2_sh[DFR_FW-1-8*k -: 8]  = shd_q[int'(DFR_ADDR_F2) + k];
      dfw_sh[DFR_FW-1-8*k -: 8] = shd_q[int'(DFR_ADDR_DFW) + k];
    end
    rrc_sh = {shd_q[int'(DFR_ADDR_RRC)][3:0], shd_q[int'(DFR_ADDR_RRC) + 1],
              shd_q[int'(DFR_ADDR_RRC) + 2]};
  end

  // active copies load only on the update pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      f1_q  <= DFR_WORD_RST;
      f2_q  <= DFR_WORD_RST;
      dfw_q <= DFR_WORD_RST;
      rrc_q <= DFR_RRC_RST;
      ctl_q <= DFR_BYTE_RST;
    end else if (update_i) begin
      f1_q  <= f1_sh;
      f2_q  <= f2_sh;
      dfw_q <= dfw_sh;
      rrc_q <= rrc_sh;
      ctl_q <= shd_q[DFR_ADDR_CTL[4:0]];
    end
  end

  assign mode      = dfr_mode_t'(ctl_q[DFR_CTL_MODE_LSB +: 3]);
  assign clr2      = ctl_q[DFR_CTL_CLR2_BIT];
  assign tri_on    = ctl_q[DFR_CTL_TRI_BIT];
  assign ramp_mode = (mode == DFR_MODE_RAMP);

  // one-shot clear on every update that carries the clear bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clr1_q <= 1'b0;
    end else begin
      clr1_q <= update_i && shd_q[DFR_ADDR_CTL[4:0]][DFR_CTL_CLR1_BIT];
    end
  end

  assign tri_rise = update_i && shd_q[DFR_ADDR_CTL[4:0]][DFR_CTL_TRI_BIT] && !tri_on;

  // keying pin synchroniser; level accepted when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_s_q <= DFR_SYNC_RST;
    end else begin
      key_s_q <= {key_s_q[1:0], keying_select_pin_i};
    end
  end

  assign key_chg = (key_s_q[1] == key_s_q[2]) && (key_s_q[2] != key_q);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      key_q <= 1'b0;
    end else if (key_chg) begin
      key_q <= key_s_q[2];
    end
  end

  // distance between the words; relies on first word being the lower
  assign span    = f2_q - f1_q;
  assign at_dest = dir_up_q ? (acc_q == span) : (acc_q == DFR_WORD_RST);
  // at an end the triangle turns round on the next tick
  assign step_up = (tri_on && at_dest) ? !dir_up_q : dir_up_q;

  // counter runs until the destination, or forever in triangle sweep
  assign rif.run     = ramp_mode && !clr2 && (tri_on || !at_dest);
  assign rif.restart = (key_chg && !tri_on) || clr1_q || tri_rise;
  assign rif.period  = rrc_q;

  // sweep direction: pin in keyed ramp, own turn-round in triangle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_up_q <= 1'b0;
    end else if (tri_rise) begin
      dir_up_q <= !key_q;
    end else if (tri_on && ramp_mode) begin
      if (rif.tick) begin
        dir_up_q <= step_up;
      end
    end else begin
      dir_up_q <= key_q;
    end
  end

  // frequency accumulator: offset above the first word
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_q <= DFR_WORD_RST;
    end else if (clr2 || !ramp_mode) begin
      acc_q <= DFR_WORD_RST;
    end else if (tri_rise) begin
      acc_q <= key_q ? span : DFR_WORD_RST;
    end else if (clr1_q) begin
      acc_q <= dir_up_q ? DFR_WORD_RST : span;
    end else if (rif.tick) begin
      if (step_up) begin
        if (dfw_q >= span - acc_q) begin
          acc_q <= span;
        end else begin
          acc_q <= acc_q + dfw_q;
        end
      end else begin
        if (dfw_q >= acc_q) begin
          acc_q <= DFR_WORD_RST;
        end else begin
          acc_q <= acc_q - dfw_q;
        end
      end
    end
  end

  // tuning word into the phase accumulator
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ftw_q <= DFR_WORD_RST;
    end else if (clr2) begin
      ftw_q <= DFR_WORD_RST;
    end else begin
      case (mode)
        DFR_MODE_FSK:  ftw_q <= key_q ? f2_q : f1_q;
        DFR_MODE_RAMP: ftw_q <= f1_q + acc_q;
        default:       ftw_q <= f1_q;
      endcase
    end
  end

  // phase accumulator never reset by a word change
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_q <= DFR_WORD_RST;
    end else if (clr2) begin
      phase_q <= DFR_WORD_RST;
    end else begin
      phase_q <= phase_q + ftw_q;
    end
  end

  // readback of shadow bytes, unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_q <= DFR_BYTE_RST;
    end else if (rd_addr_i < 6'(DFR_NREG)) begin
      rd_data_q <= shd_q[rd_addr_i[4:0]];
    end else begin
      rd_data_q <= DFR_BYTE_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= rif.run;
    end
  end

  assign rd_data_o     = rd_data_q;
  assign tuning_word_o = ftw_q;
  assign phase_o       = phase_q;
  assign ramp_busy_o   = busy_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_FSK_SELECT: assert property (
    (mode == DFR_MODE_FSK && !clr2) |=>
      (ftw_q == ($past(key_q) ? $past(f2_q) : $past(f1_q))))
    else $error("keyed word select wrong");

  AST_SINGLE_TONE: assert property (
    (mode == DFR_MODE_SINGLE && !clr2) |=> (ftw_q == $past(f1_q)))
    else $error("single tone word wrong");

  AST_PHASE_CONT: assert property (
    !clr2 |=> (phase_q == 48'($past(phase_q) + $past(ftw_q))))
    else $error("phase accumulator lost continuity");

  AST_RAMP_STEP: assert property (
    (ramp_mode && !clr2 && !tri_rise && !clr1_q && rif.tick && step_up &&
     dfw_q < span - acc_q) |=> (acc_q == 48'($past(acc_q) + $past(dfw_q))))
    else $error("ramp step not added");

  AST_CLAMP: assert property (
    (ramp_mode && !clr2 && !tri_rise && !clr1_q && rif.tick && step_up &&
     dfw_q >= span - acc_q) |=> (acc_q == $past(span)))
    else $error("ramp overshot destination");

  AST_PARK: assert property (
    (ramp_mode && !tri_on && at_dest && !key_chg && !clr1_q && !update_i)
      |=> $stable(acc_q))
    else $error("parked frequency moved");

  AST_FULL_CLEAR: assert property (
    clr2 |=> (acc_q == '0 && phase_q == '0 && ftw_q == '0))
    else $error("full clear not held");

  AST_ONE_SHOT: assert property (
    (clr1_q && ramp_mode && !clr2 && !tri_rise) |=>
      (acc_q == ($past(dir_up_q) ? '0 : $past(span))) ##1 (!clr1_q || $past(update_i)))
    else $error("accumulator clear wrong");

  AST_TRI_START: assert property (
    (tri_rise && ramp_mode && !clr2) |=> (dir_up_q == !$past(key_q)))
    else $error("triangle start direction wrong");

  AST_REVERSE: assert property (
    (ramp_mode && !tri_on && !tri_rise && key_chg) |=> ##1 (dir_up_q == $past(key_q)))
    else $error("ramp did not follow pin");

  AST_STEP_DOWN: assert property (
    (ramp_mode && !clr2 && !tri_rise && !clr1_q && rif.tick && !step_up &&
     dfw_q < acc_q) |=> (acc_q == 48'($past(acc_q) - $past(dfw_q))))
    else $error("ramp step not subtracted");

  AST_CLAMP_LOW: assert property (
    (ramp_mode && !clr2 && !tri_rise && !clr1_q && rif.tick && !step_up &&
     dfw_q >= acc_q) |=> (acc_q == '0))
    else $error("ramp passed the first word");

  AST_RAMP_WORD: assert property (
    (ramp_mode && !clr2) |=> (ftw_q == 48'($past(f1_q) + $past(acc_q))))
    else $error("ramped tuning word wrong");

  AST_TRI_TURN: assert property (
    (ramp_mode && tri_on && !tri_rise && !clr2 && rif.tick && at_dest)
      |=> (dir_up_q != $past(dir_up_q)))
    else $error("triangle did not turn at an end");

  AST_TRI_NO_PIN: assert property (
    (ramp_mode && tri_on && !tri_rise && !rif.tick) |=> $stable(dir_up_q))
    else $error("triangle direction moved off a tick");

  AST_PARK_WORD: assert property (
    (ramp_mode && !clr2 && !tri_on && at_dest && dir_up_q) |=>
      (ftw_q == $past(f2_q)))
    else $error("parked word is not the second word");

  COV_FSK_SWITCH: cover property (mode == DFR_MODE_FSK && key_chg);
  COV_RAMP_DONE: cover property (ramp_mode && !tri_on && $fell(rif.run));
  COV_TRI_TURN: cover property (ramp_mode && tri_on && rif.tick && at_dest);
  COV_CLR1: cover property (ramp_mode && clr1_q && at_dest);
  COV_REVERSE: cover property (ramp_mode && !tri_on && key_chg && !at_dest);

endmodule : dfr_freq_ctl

// >>> dfr_host_model.sv
// partner host: register writes, update pulses, read address and keying pin
// assumes every drive lands just after a rising clk_i edge
module dfr_host_model
  import dfr_pkg::*;
(
  // clock
  input  wire logic          clk_i,
  // programming port
  output logic               wr_en_o,
  output logic [DFR_AW-1:0]  wr_addr_o,
  output logic [7:0]         wr_data_o,
  output logic               update_o,
  output logic [DFR_AW-1:0]  rd_addr_o,
  // keying pin
  output logic               pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 6'h00;
    wr_data_o = 8'h00;
    update_o = 1'b0;
    rd_addr_o = 6'h00;
    pin_o = 1'b0;
  end

  // msb byte at the base offset
  task automatic wr_bytes(input logic [5:0] a, input logic [47:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      wr_addr_o <= a + 6'(i);
      wr_data_o <= 8'(v >> (8 * (n - 1 - i)));
    end
    @(posedge clk_i);
    wr_en_o <= 1'b0;
  endtask : wr_bytes

  task automatic load_words(input logic [47:0] lo, input logic [47:0] hi, input logic [47:0] st,
                            input logic [19:0] per);
    wr_bytes(DFR_ADDR_F1, lo, 6);
    wr_bytes(DFR_ADDR_F2, hi, 6);
    wr_bytes(DFR_ADDR_DFW, st, 6);
    wr_bytes(DFR_ADDR_RRC, 48'((per == 20'h0) ? 20'h1 : per), 3);
  endtask : load_words

  task automatic ctl(input logic [7:0] c);
    wr_bytes(DFR_ADDR_CTL, 48'(c), 1);
    @(posedge clk_i);
    update_o <= 1'b1;
    @(posedge clk_i);
    update_o <= 1'b0;
  endtask : ctl

  task automatic set_pin(input logic v);
    @(posedge clk_i);
    pin_o <= v;
  endtask : set_pin

  task automatic rd_set(input logic [5:0] a);
    @(posedge clk_i);
    rd_addr_o <= a;
  endtask : rd_set
endmodule : dfr_host_model

// >>> dfr_freq_ctl_tb.sv
// self-checking bench for the keyed frequency select and ramp block
// assumes dfr_host_model drives the programming port and keying pin
module dfr_freq_ctl_tb
  import dfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst_b, wr_en, update, pin, busy, lvl;
  logic [5:0] wr_addr, rd_addr, ra;
  logic [7:0] wr_data, rd_data;
  logic [47:0] tw, ph, f1, f2, d, v, p0, t0;
  logic [19:0] per;
  int seed = 32'h13d999da;
  int err_count, compares, gap;

  always #10 clk = ~clk;

  dfr_host_model host (.clk_i(clk), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
                       .update_o(update), .rd_addr_o(rd_addr), .pin_o(pin));
  dfr_freq_ctl uut (.clk_i(clk), .rst_b_i(rst_b), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
                    .wr_data_i(wr_data), .update_i(update), .rd_addr_i(rd_addr),
                    .rd_data_o(rd_data), .keying_select_pin_i(pin), .tuning_word_o(tw),
                    .phase_o(ph), .ramp_busy_o(busy));

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    host.rd_set(a);
    @(posedge clk);
    @(negedge clk);
    chk_byte(rd_data, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  // phase grows by the tuning word, restarts only on full clear
  task automatic chk_phase();
    @(negedge clk);
    p0 = ph;
    t0 = tw;
    @(negedge clk);
    chk_word(ph, p0 + t0);
  endtask : chk_phase

  task automatic next_tw(output logic [47:0] nv, output int g);
    logic [47:0] last;
    last = tw;
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (tw === last && g < 400);
    nv = tw;
    if (tw === last) begin
      err_count++;
      close_out();
    end
  endtask : next_tw

  function automatic logic [47:0] step_to(input logic [47:0] cur, input logic [47:0] dst);
    if (dst > cur) return (dst - cur > d) ? cur + d : dst;
    return (cur - dst > d) ? cur - d : dst;
  endfunction : step_to

  task automatic run_to(input logic [47:0] dst);
    logic [47:0] e;
    int k;
    e = tw;
    k = 0;
    while (e !== dst && k < 8) begin
      e = step_to(e, dst);
      next_tw(v, gap);
      chk_word(v, e);
      if (k > 0) chk_word(48'(gap), 48'(per) + 48'h1);
      if (e !== dst) chk_byte({7'h00, busy}, 8'h01);
      k++;
    end
  endtask : run_to

  // byte b of a word written msb first at base, zero outside it
  function automatic logic [7:0] byte_in(input logic [47:0] w, input int base, input int n,
                                         input int b);
    return (b >= base && b < base + n) ? 8'(w >> (8 * (base + n - 1 - b))) : 8'h00;
  endfunction : byte_in

  function automatic logic [7:0] shadow_exp(input logic [5:0] a);
    return byte_in(f1, int'(DFR_ADDR_F1), int'(DFR_WORD_BYTES), int'(a)) |
           byte_in(f2, int'(DFR_ADDR_F2), int'(DFR_WORD_BYTES), int'(a)) |
           byte_in(d, int'(DFR_ADDR_DFW), int'(DFR_WORD_BYTES), int'(a)) |
           byte_in(48'(per), int'(DFR_ADDR_RRC), 3, int'(a));
  endfunction : shadow_exp

  task automatic pin_to(input logic lv);
    host.set_pin(lv);
  endtask : pin_to

  task automatic ctl_to(input logic clr1, input logic clr2, input logic sweep,
                        input dfr_mode_t m);
    logic [7:0] c;
    c = 8'h00;
    c[DFR_CTL_CLR1_BIT] = clr1;
    c[DFR_CTL_CLR2_BIT] = clr2;
    c[DFR_CTL_TRI_BIT] = sweep;
    c[DFR_CTL_MODE_LSB +: 3] = m;
    host.ctl(c);
  endtask : ctl_to

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    f1 = {2'b00, 46'({$random(seed), $random(seed)})};
    d = 48'({$random(seed)}) | 48'h100;
    f2 = f1 + 48'h2 * d + (d >> 1);
    per = 20'(8 + {$random(seed)} % 8);
    host.load_words(f1, f2, d, per);
    rd(6'h09, f1[7:0]);
    rd(6'h0a, f2[47:40]);
    rd(6'h1a, {4'h0, per[19:16]});
    rd(6'h20, 8'h00);
    repeat (8) begin
      ra = 6'($random(seed));
      rd(ra, shadow_exp(ra));
    end
    $display("test register readback done");
    ctl_to(1'b0, 1'b0, 1'b0, DFR_MODE_SINGLE);
    settle(6);
    chk_word(tw, f1);
    chk_phase();
    ctl_to(1'b0, 1'b0, 1'b0, DFR_MODE_FSK);
    settle(6);
    chk_word(tw, f1);
    repeat (4) begin
      lvl = 1'($random(seed));
      pin_to(lvl);
      settle(8);
      chk_word(tw, lvl ? f2 : f1);
    end
    pin_to(1'b1);
    settle(8);
    chk_word(tw, f2);
    chk_phase();
    $display("test unramped keying done");
    ctl_to(1'b1, 1'b0, 1'b0, DFR_MODE_RAMP);
    next_tw(v, gap);
    chk_word(v, f1);
    ctl_to(1'b0, 1'b0, 1'b0, DFR_MODE_RAMP);
    run_to(f2);
    settle(3 * (int'(per) + 1));
    chk_word(tw, f2);
    chk_byte({7'h00, busy}, 8'h00);
    pin_to(1'b0);
    run_to(f1);
    pin_to(1'b1);
    next_tw(v, gap);
    chk_word(v, f1 + d);
    pin_to(1'b0);
    next_tw(v, gap);
    chk_word(v, f1);
    $display("test ramped keying done");
    settle(20);
    ctl_to(1'b1, 1'b0, 1'b0, DFR_MODE_RAMP);
    next_tw(v, gap);
    chk_word(v, f2);
    ctl_to(1'b0, 1'b0, 1'b0, DFR_MODE_RAMP);
    run_to(f1);
    $display("test accumulator clear done");
    ctl_to(1'b0, 1'b0, 1'b1, DFR_MODE_RAMP);
    pin_to(1'b1);
    run_to(f2);
    run_to(f1);
    $display("test triangle sweep done");
    ctl_to(1'b0, 1'b1, 1'b0, DFR_MODE_RAMP);
    settle(6);
    chk_word(tw, 48'h0);
    settle(4);
    chk_word(ph, 48'h0);
    pin_to(1'b0);
    ctl_to(1'b0, 1'b0, 1'b0, DFR_MODE_SINGLE);
    settle(8);
    chk_word(tw, f1);
    $display("test full clear done");
    close_out();
  end
endmodule : dfr_freq_ctl_tb
